// *** design/itc_io_t2_ctrl.sv ***
// What this block does
// R1 - Port 1 high-impedance bit set stops port 1 output drive.
// R2 - Port 2 high-impedance bit set stops port 2 output drive.
// R3 - Port 3 high-impedance bit set stops port 3 output drive.
// R4 - Cascade bit chains timers 0 and 1; 32-bit carry sets timer 1 overflow.
// R5 - Top bit of the I/O control register always reads zero.
// R6 - Timer 2 counts while run bit is one, holds while zero.
// R7 - Timer 2 external control input acts only while its enable is one.
// R8 - Transmit clock select picks the serial transmitter clock source.
// R9 - With transmit clock select set, timer 2 becomes the baud generator.
// R10 - Serial receive error flag set by hardware, kept until software clears.
// R11 - Power-down with float bit set floats ports 0 to 3; else they drive.
module itc_io_t2_ctrl #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Power-down and serial events
  input wire logic soft_powerdown_i,
  input wire logic hard_powerdown_i,
  input wire logic serial_rx_error_i,
  // Timer inputs
  input wire logic t0_tick_i,
  input wire logic t1_tick_i,
  input wire logic t2_int_tick_i,
  input wire logic t2_ext_tick_i,
  input wire logic timer_two_ext_control_in_i,
  input wire logic [CNT_W-1:0] t2_reload_i,
  // Timer outputs
  output logic [CNT_W-1:0] t2_capture_o,
  output logic timer_one_overflow_flag_set_o,
  output logic tx_clk_tick_o,
  // Port controls
  output logic [3:0] port_drive_en_o,
  output logic strong_pullup_off_o,
  // Interrupt
  output logic irq_o
);
  itc_timer_if #(.CNT_W(CNT_W)) tbus ();

  logic [7:0] io_port_control_reg, io_port_control_next;
  logic [7:0] timer_two_control_reg, timer_two_control_next;
  logic [itc_pkg::EV_COUNT-1:0] irq_stat_reg, irq_stat_next;
  logic [itc_pkg::EV_COUNT-1:0] irq_mask_reg, irq_mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic t1_ovf_reg, tx_tick_reg;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offs);
    addr_hit = (addr == offs);
  endfunction : addr_hit

  // Address decode
  wire wr_io = reg_wr_i & addr_hit(reg_addr_i, itc_pkg::ADDR_IO_CTRL);
  wire wr_t2 = reg_wr_i & addr_hit(reg_addr_i, itc_pkg::ADDR_T2_CTRL);
  wire wr_mask = reg_wr_i & addr_hit(reg_addr_i, itc_pkg::ADDR_IRQ_MASK);
  wire rd_stat = reg_rd_i & addr_hit(reg_addr_i, itc_pkg::ADDR_IRQ_STAT);

  // Control fields
  wire float_en = io_port_control_reg[itc_pkg::IO_FLOAT];
  wire serial_rx_error_flag = io_port_control_reg[itc_pkg::IO_SER_ERR];
  wire timer_two_overflow_flag = timer_two_control_reg[itc_pkg::T2_OVF_FLAG];
  wire timer_two_ext_flag = timer_two_control_reg[itc_pkg::T2_EXT_FLAG];
  wire tx_clock_select = timer_two_control_reg[itc_pkg::T2_TX_CLK];
  wire powered_down = soft_powerdown_i | hard_powerdown_i;
  wire ports_float = powered_down & float_en; // R11

  // Port 0 has no high-impedance bit of its own
  wire [3:0] port_hiz = {io_port_control_reg[itc_pkg::IO_P3_HIZ],
    io_port_control_reg[itc_pkg::IO_P2_HIZ], io_port_control_reg[itc_pkg::IO_P1_HIZ], 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_port
      assign port_drive_en_o[gi] = ~port_hiz[gi] & ~ports_float; // R1 R2 R3 R11
    end
  endgenerate

  assign strong_pullup_off_o = io_port_control_reg[itc_pkg::IO_PULLUP_OFF];

  // Timer control towards the counters
  assign tbus.cascade_en = io_port_control_reg[itc_pkg::IO_CASCADE]; // R4
  assign tbus.t2_run = timer_two_control_reg[itc_pkg::T2_RUN]; // R6
  assign tbus.t2_ext_en = timer_two_control_reg[itc_pkg::T2_EXT_EN]; // R7
  assign tbus.t2_clk_src = timer_two_control_reg[itc_pkg::T2_CLK_SRC];
  assign tbus.t2_cap_sel = timer_two_control_reg[itc_pkg::T2_CAP_SEL];
  assign tbus.t2_baud_mode = tx_clock_select | timer_two_control_reg[itc_pkg::T2_RX_CLK]; // R9

  itc_timers #(.CNT_W(CNT_W)) u_timers (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .t0_tick_i(t0_tick_i),
    .t1_tick_i(t1_tick_i),
    .t2_int_tick_i(t2_int_tick_i),
    .t2_ext_tick_i(t2_ext_tick_i),
    .t2_ext_ctrl_i(timer_two_ext_control_in_i),
    .t2_reload_i(t2_reload_i),
    .t2_capture_o(t2_capture_o),
    .tb(tbus)
  );

  // I/O control: error flag set wins over a software clear
  wire serial_rx_error_flag_keep = wr_io ? reg_wdata_i[itc_pkg::IO_SER_ERR] : serial_rx_error_flag;
  assign io_port_control_next = {1'b0, // R5
    wr_io ? reg_wdata_i[itc_pkg::IO_CASCADE] : io_port_control_reg[itc_pkg::IO_CASCADE],
    serial_rx_error_i | serial_rx_error_flag_keep, // R10
    wr_io ? reg_wdata_i[4:0] : io_port_control_reg[4:0]};

  // Timer 2 control: hardware flags win over a software clear
  wire tf2_keep = wr_t2 ? reg_wdata_i[itc_pkg::T2_OVF_FLAG] : timer_two_overflow_flag;
  wire timer_two_ext_flag_keep = wr_t2 ? reg_wdata_i[itc_pkg::T2_EXT_FLAG] : timer_two_ext_flag;
  assign timer_two_control_next = {tbus.t2_overflow | tf2_keep,
    tbus.t2_ext_event | timer_two_ext_flag_keep, // R7
    wr_t2 ? reg_wdata_i[5:0] : timer_two_control_reg[5:0]};

  // Interrupt status: read clears, new event wins
  wire [itc_pkg::EV_COUNT-1:0] irq_events = {tbus.t2_ext_event, tbus.t2_overflow,
    tbus.t1_carry, serial_rx_error_i};
  assign irq_stat_next = irq_events | (rd_stat ? '0 : irq_stat_reg);
  assign irq_mask_next = wr_mask ? reg_wdata_i[itc_pkg::EV_COUNT-1:0] : irq_mask_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // Count bytes, zero-filled above the counter width
  wire [15:0] t2_count_wide = 16'(tbus.t2_count);

  // Read mux, unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      itc_pkg::ADDR_IO_CTRL: rd_mux = {1'b0, io_port_control_reg[6:0]}; // R5
      itc_pkg::ADDR_T2_CTRL: rd_mux = timer_two_control_reg;
      itc_pkg::ADDR_IRQ_STAT: rd_mux = {4'h0, irq_stat_reg};
      itc_pkg::ADDR_IRQ_MASK: rd_mux = {4'h0, irq_mask_reg};
      itc_pkg::ADDR_T2_CNT_LO: rd_mux = t2_count_wide[7:0];
      itc_pkg::ADDR_T2_CNT_HI: rd_mux = t2_count_wide[15:8];
      default: rd_mux = 8'h00;
    endcase
  end
  assign rdata_next = reg_rd_i ? rd_mux : 8'h00;
  assign reg_rdata_o = rdata_reg;

  assign timer_one_overflow_flag_set_o = t1_ovf_reg;
  assign tx_clk_tick_o = tx_tick_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      io_port_control_reg <= itc_pkg::RST_IO_CTRL;
      timer_two_control_reg <= itc_pkg::RST_T2_CTRL;
      irq_stat_reg <= '0;
      irq_mask_reg <= itc_pkg::RST_IRQ_MASK;
      rdata_reg <= 8'h00;
      t1_ovf_reg <= 1'b0;
      tx_tick_reg <= 1'b0;
    end else begin
      io_port_control_reg <= io_port_control_next;
      timer_two_control_reg <= timer_two_control_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
      t1_ovf_reg <= tbus.t1_carry; // R4
      // Transmit clock source select
      tx_tick_reg <= tx_clock_select ? tbus.t2_baud_tick : tbus.t1_carry; // R8
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  port_one_hiz_a: assert property ( // R1
    wr_io && reg_wdata_i[itc_pkg::IO_P1_HIZ] |=> !port_drive_en_o[1] ##1 !port_drive_en_o[1])
    else $error("port 1 drives after high-impedance write");
  port_two_hiz_a: assert property ( // R2
    wr_io && reg_wdata_i[itc_pkg::IO_P2_HIZ] |=> !port_drive_en_o[2])
    else $error("port 2 drives after high-impedance write");
  port_three_hiz_a: assert property ( // R3
    wr_io && reg_wdata_i[itc_pkg::IO_P3_HIZ] |=> !port_drive_en_o[3])
    else $error("port 3 drives after high-impedance write");
  cascade_flag_a: assert property ( // R4
    tbus.t1_carry |=> timer_one_overflow_flag_set_o && irq_stat_reg[itc_pkg::EV_T1_OVF])
    else $error("cascade carry did not raise timer 1 overflow");
  reserved_zero_a: assert property ( // R5
    reg_rd_i && addr_hit(reg_addr_i, itc_pkg::ADDR_IO_CTRL) |=> reg_rdata_o[7] == 1'b0)
    else $error("reserved bit read as one");
  ext_flag_gate_a: assert property ( // R7
    !tbus.t2_ext_en && !wr_t2 && !timer_two_ext_flag |=> !timer_two_ext_flag)
    else $error("external flag set while input disabled");
  tx_source_a: assert property ( // R8
    !tx_clock_select && tbus.t1_carry |=> tx_clk_tick_o)
    else $error("timer 1 carry did not clock the transmitter");
  baud_tick_a: assert property ( // R9
    tx_clock_select && tbus.t2_baud_tick |=> tx_clk_tick_o && !$rose(timer_two_overflow_flag))
    else $error("baud generator tick lost or flag raised");
  serial_rx_error_flag_sticky_a: assert property ( // R10
    serial_rx_error_i |=> serial_rx_error_flag ##1 (serial_rx_error_flag || $past(wr_io)))
    else $error("receive error flag not held");
  float_power_a: assert property ( // R11
    powered_down && float_en |-> port_drive_en_o == 4'h0)
    else $error("ports drive in power-down with float set");
  drive_power_a: assert property ( // R11
    powered_down && !float_en && io_port_control_reg[3:1] == 3'h0 |-> port_drive_en_o == 4'hf)
    else $error("ports float without float bit");
  irq_level_a: assert property (
    serial_rx_error_i && irq_mask_reg[itc_pkg::EV_SER_ERR] && !wr_mask |=> irq_o)
    else $error("masked-in event did not raise interrupt");

  cascade_carry_c: cover property (tbus.cascade_en && tbus.t1_carry);
  baud_tick_c: cover property (tx_clock_select && tbus.t2_baud_tick);
  serial_rx_error_flag_clear_c: cover property (serial_rx_error_flag ##1 wr_io ##1 !serial_rx_error_flag);
  irq_clear_c: cover property (irq_o ##1 rd_stat ##1 !irq_o);
endmodule : itc_io_t2_ctrl

// *** design/itc_pkg.sv ***
package itc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_T2_CTRL = 8'hc8;
  localparam logic [7:0] ADDR_IO_CTRL = 8'hf8;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
  localparam logic [7:0] ADDR_T2_CNT_LO = 8'h48;
  localparam logic [7:0] ADDR_T2_CNT_HI = 8'h4c;

  // io_port_control fields
  localparam int IO_FLOAT = 0;
  localparam int IO_P1_HIZ = 1;
  localparam int IO_P2_HIZ = 2;
  localparam int IO_P3_HIZ = 3;
  localparam int IO_PULLUP_OFF = 4;
  localparam int IO_SER_ERR = 5;
  localparam int IO_CASCADE = 6;
  localparam int IO_RESERVED = 7;

  // timer_two_control fields
  localparam int T2_CAP_SEL = 0;
  localparam int T2_CLK_SRC = 1;
  localparam int T2_RUN = 2;
  localparam int T2_EXT_EN = 3;
  localparam int T2_TX_CLK = 4;
  localparam int T2_RX_CLK = 5;
  localparam int T2_EXT_FLAG = 6;
  localparam int T2_OVF_FLAG = 7;

  // Interrupt status and mask layout
  localparam int EV_SER_ERR = 0;
  localparam int EV_T1_OVF = 1;
  localparam int EV_T2_OVF = 2;
  localparam int EV_T2_EXT = 3;
  localparam int EV_COUNT = 4;

  // Reset values
  localparam logic [7:0] RST_IO_CTRL = 8'h00;
  localparam logic [7:0] RST_T2_CTRL = 8'h00;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;

endpackage : itc_pkg

// *** design/itc_timer_if.sv ***
interface itc_timer_if #(
  parameter int CNT_W = 16
);
  logic cascade_en;
  logic t2_run;
  logic t2_ext_en;
  logic t2_clk_src;
  logic t2_cap_sel;
  logic t2_baud_mode;
  logic t1_carry;
  logic t2_overflow;
  logic t2_ext_event;
  logic t2_baud_tick;
  logic [CNT_W-1:0] t2_count;

  modport ctl (
    output cascade_en, t2_run, t2_ext_en, t2_clk_src, t2_cap_sel, t2_baud_mode,
    input t1_carry, t2_overflow, t2_ext_event, t2_baud_tick, t2_count
  );
  modport tmr (
    input cascade_en, t2_run, t2_ext_en, t2_clk_src, t2_cap_sel, t2_baud_mode,
    output t1_carry, t2_overflow, t2_ext_event, t2_baud_tick, t2_count
  );
endinterface : itc_timer_if

// *** design/itc_timers.sv ***
module itc_timers #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Count ticks
  input wire logic t0_tick_i,
  input wire logic t1_tick_i,
  input wire logic t2_int_tick_i,
  input wire logic t2_ext_tick_i,
  input wire logic t2_ext_ctrl_i,
  // Timer 2 reload and capture
  input wire logic [CNT_W-1:0] t2_reload_i,
  output logic [CNT_W-1:0] t2_capture_o,
  // Control side
  itc_timer_if.tmr tb
);
  logic [CNT_W-1:0] t0_reg, t0_next, t1_reg, t1_next, t2_reg, t2_next;
  logic [CNT_W-1:0] cap_reg, cap_next;
  logic ext_prev_reg;

  wire t0_full = &t0_reg;
  wire t1_full = &t1_reg;
  wire t2_full = &t2_reg;
  wire t0_carry = t0_tick_i & t0_full;
  // Cascade: timer 1 steps on the timer 0 carry only
  wire t1_step = tb.cascade_en ? t0_carry : t1_tick_i; // R4
  wire t2_tick = tb.t2_run & (tb.t2_clk_src ? t2_ext_tick_i : t2_int_tick_i); // R6
  wire ext_edge = ext_prev_reg & ~t2_ext_ctrl_i;
  wire ext_evt = tb.t2_ext_en & ext_edge; // R7
  wire t2_ovf = t2_tick & t2_full;
  wire do_reload = tb.t2_run & ((t2_ovf & (tb.t2_baud_mode | ~tb.t2_cap_sel))
    | (ext_evt & ~tb.t2_baud_mode & ~tb.t2_cap_sel));
  wire do_capture = ext_evt & ~tb.t2_baud_mode & tb.t2_cap_sel;

  assign t0_next = t0_tick_i ? t0_reg + 1'b1 : t0_reg;
  assign t1_next = t1_step ? t1_reg + 1'b1 : t1_reg;
  assign t2_next = do_reload ? t2_reload_i : (t2_tick ? t2_reg + 1'b1 : t2_reg); // R6
  assign cap_next = do_capture ? t2_reg : cap_reg;

  assign tb.t1_carry = t1_step & t1_full; // R4
  // Baud mode: overflow becomes the baud tick, not the flag
  assign tb.t2_overflow = t2_ovf & ~tb.t2_baud_mode; // R9
  assign tb.t2_baud_tick = t2_ovf & tb.t2_baud_mode; // R9
  assign tb.t2_ext_event = ext_evt; // R7
  assign tb.t2_count = t2_reg;
  assign t2_capture_o = cap_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      t0_reg <= '0;
      t1_reg <= '0;
      t2_reg <= '0;
      cap_reg <= '0;
      ext_prev_reg <= 1'b1;
    end else begin
      t0_reg <= t0_next;
      t1_reg <= t1_next;
      t2_reg <= t2_next;
      cap_reg <= cap_next;
      ext_prev_reg <= t2_ext_ctrl_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  cascade_wrap_a: assert property ( // R4
    tb.cascade_en && t0_tick_i && t0_full && t1_full |=> t0_reg == '0 && t1_reg == '0)
    else $error("cascaded counter did not wrap to zero");
  t2_halt_a: assert property (!tb.t2_run |=> $stable(t2_reg)) // R6
    else $error("timer 2 moved while halted");
  ext_ignore_a: assert property ($fell(t2_ext_ctrl_i) && !tb.t2_ext_en |-> !tb.t2_ext_event) // R7
    else $error("external control acted on while disabled");
  baud_no_flag_a: assert property ( // R9
    tb.t2_baud_mode && t2_tick && t2_full |-> tb.t2_baud_tick && !tb.t2_overflow ##1
    t2_reg == $past(t2_reload_i))
    else $error("baud overflow did not reload or raised the flag");
endmodule : itc_timers

// *** verification/io_and_timer2_control_regs_tb.sv ***
module io_and_timer2_control_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CW = 4;

  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic soft_powerdown_i = 1'b0;
  logic hard_powerdown_i = 1'b0;
  logic serial_rx_error_i = 1'b0;
  logic t0_tick_i = 1'b0;
  logic t1_tick_i = 1'b0;
  logic t2_int_tick_i = 1'b0;
  logic t2_ext_tick_i = 1'b0;
  logic timer_two_ext_control_in_i = 1'b1;
  logic [CW-1:0] t2_reload_i = 4'he;
  logic [CW-1:0] t2_capture_o;
  logic timer_one_overflow_flag_set_o;
  logic tx_clk_tick_o;
  logic [3:0] port_drive_en_o;
  logic strong_pullup_off_o;
  logic irq_o;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ovf_cnt = 0;
  int tx_cnt = 0;
  int n;
  int exp_tx;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [31:0] lfsr = 32'hf2b8;

  itc_io_t2_ctrl #(.CNT_W(CW)) u_itc_io_t2_ctrl (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .soft_powerdown_i(soft_powerdown_i),
    .hard_powerdown_i(hard_powerdown_i), .serial_rx_error_i(serial_rx_error_i),
    .t0_tick_i(t0_tick_i), .t1_tick_i(t1_tick_i), .t2_int_tick_i(t2_int_tick_i),
    .t2_ext_tick_i(t2_ext_tick_i), .timer_two_ext_control_in_i(timer_two_ext_control_in_i),
    .t2_reload_i(t2_reload_i), .t2_capture_o(t2_capture_o),
    .timer_one_overflow_flag_set_o(timer_one_overflow_flag_set_o),
    .tx_clk_tick_o(tx_clk_tick_o), .port_drive_en_o(port_drive_en_o),
    .strong_pullup_off_o(strong_pullup_off_o), .irq_o(irq_o)
  );

  always #2 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Read results arrive one cycle after the strobe
  always @(posedge clk_i) begin
    if (timer_one_overflow_flag_set_o === 1'b1) ovf_cnt <= ovf_cnt + 1;
    if (tx_clk_tick_o === 1'b1) tx_cnt <= tx_cnt + 1;
    if (rd_seen) check(reg_rdata_o, exp_q.pop_front());
    rd_seen <= reg_rd_i;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] expv);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(expv);
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask : rd

  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask : settle

  task automatic tick(input int which, input int num);
    for (int i = 0; i < num; i++) begin
      @(posedge clk_i);
      t0_tick_i <= (which == 0);
      t1_tick_i <= (which == 1);
      t2_int_tick_i <= (which == 2);
      t2_ext_tick_i <= (which == 3);
      @(posedge clk_i);
      t0_tick_i <= 1'b0;
      t1_tick_i <= 1'b0;
      t2_int_tick_i <= 1'b0;
      t2_ext_tick_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic ext_fall;
    @(posedge clk_i);
    timer_two_ext_control_in_i <= 1'b0;
    @(posedge clk_i);
    timer_two_ext_control_in_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : ext_fall

  task automatic rx_err;
    @(posedge clk_i);
    serial_rx_error_i <= 1'b1;
    @(posedge clk_i);
    serial_rx_error_i <= 1'b0;
    settle();
  endtask : rx_err

  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    lfsr = lfsr_next(lfsr);
    rd(8'hf8, 8'h00);
    rd(8'hc8, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h44, 8'h00);
    wr(8'h00, lfsr[7:0]);
    rd(8'h00, 8'h00);
    settle();
    check({4'h0, port_drive_en_o}, 8'h0f);
    for (int i = 1; i < 4; i++) begin
      wr(8'hf8, 8'h01 << i);
      settle();
      check({4'h0, port_drive_en_o}, 8'h0f & ~(8'h01 << i));
    end
    wr(8'hf8, 8'hff);
    rd(8'hf8, 8'h7f);
    settle();
    check({7'h00, strong_pullup_off_o}, 8'h01);
    wr(8'hf8, 8'h01);
    soft_powerdown_i <= 1'b1;
    settle();
    check({4'h0, port_drive_en_o}, 8'h00);
    soft_powerdown_i <= 1'b0;
    hard_powerdown_i <= 1'b1;
    settle();
    check({4'h0, port_drive_en_o}, 8'h00);
    wr(8'hf8, 8'h00);
    settle();
    check({4'h0, port_drive_en_o}, 8'h0f);
    hard_powerdown_i <= 1'b0;
    rx_err();
    check({7'h00, irq_o}, 8'h00);
    wr(8'h44, 8'h01);
    settle();
    check({7'h00, irq_o}, 8'h01);
    rd(8'hf8, 8'h20);
    rd(8'hf8, 8'h20);
    rd(8'h40, 8'h01);
    settle();
    check({7'h00, irq_o}, 8'h00);
    wr(8'hf8, 8'h00);
    rd(8'hf8, 8'h00);
    tick(1, 16);
    check(8'(ovf_cnt), 8'd1);
    check(8'(tx_cnt), 8'd1);
    rd(8'h40, 8'h02);
    wr(8'hf8, 8'h40);
    tick(1, 20);
    tick(0, 255);
    check(8'(ovf_cnt), 8'd1);
    tick(0, 1);
    check(8'(ovf_cnt), 8'd2);
    rd(8'h40, 8'h02);
    wr(8'hf8, 8'h00);
    lfsr = lfsr_next(lfsr);
    n = int'(lfsr % 12) + 1;
    wr(8'hc8, 8'h04);
    tick(2, n);
    rd(8'h48, 8'(n));
    wr(8'hc8, 8'h00);
    tick(2, 3);
    rd(8'h48, 8'(n));
    wr(8'hc8, 8'h01);
    ext_fall();
    rd(8'hc8, 8'h01);
    settle();
    check({4'h0, t2_capture_o}, 8'h00);
    wr(8'hc8, 8'h09);
    ext_fall();
    rd(8'hc8, 8'h49);
    rd(8'h40, 8'h08);
    settle();
    check({4'h0, t2_capture_o}, 8'(n));
    wr(8'hc8, 8'h14);
    exp_tx = tx_cnt + 1 + (40 - (16 - n)) / 2;
    tick(2, 40);
    check(8'(tx_cnt), 8'(exp_tx));
    check(8'(ovf_cnt), 8'd2);
    rd(8'hc8, 8'h14);
    // External clock source, reload mode: one overflow sets the flag
    wr(8'hc8, 8'h06);
    tick(3, 2);
    rd(8'hc8, 8'h86);
    rd(8'h40, 8'h04);
    repeat (4) @(posedge clk_i);
    give_verdict();
  end
endmodule : io_and_timer2_control_regs_tb
